// file: core/rdc_defs.svh
// Purpose: Constants for the reset and device configuration block
// Assumes: 20 MHz system clock
// Notes:   Fields of the setup word and timing counts
`ifndef RDC_DEFS_SVH
`define RDC_DEFS_SVH

`define RDC_SETUP_ADDR      14'h2007
`define RDC_CALIB_ADDR      14'h2008
`define RDC_SPECIAL_LO      14'h2000
`define RDC_SPECIAL_HI      14'h3FFF
`define RDC_SETUP_RESET     16'hFFFF
`define RDC_UNIMPL_MASK     16'hFC00
`define RDC_CALIB_RESET     16'h0000
`define RDC_DROOP_HI        9
`define RDC_DROOP_LO        8
`define RDC_OSC_SPEED_BIT   7
`define RDC_CODE_LOCK_BIT   6
`define RDC_EXT_RST_BIT     5
`define RDC_PUD_OFF_BIT     4
`define RDC_WDOG_ON_BIT     3
`define RDC_CLKSRC_HI       2
`define RDC_CLKSRC_LO       0
`define RDC_CLK_HZ          20000000
`define RDC_PUD_MS          64
`define RDC_PUD_CYCLES      (`RDC_CLK_HZ / 1000 * `RDC_PUD_MS)
`define RDC_SETTLE_TICKS    1024
`define RDC_FILTER_CYCLES   4
`define RDC_RCDIV_CYCLES    8

`endif

// file: core/rdc_pkg.sv
// Purpose: Types for the reset and device configuration block
// Assumes: Nothing beyond the constants header
// Notes:   Clock source modes and reset cause flags
package rdc_pkg;

   typedef enum logic [2:0] {
      RDC_LOW_POWER_CRYSTAL      = 3'h0,
      RDC_STANDARD_CRYSTAL       = 3'h1,
      RDC_FAST_CRYSTAL           = 3'h2,
      RDC_EXTERNAL_CLOCK_INPUT   = 3'h3,
      RDC_INTERNAL_OSC_PINS_FREE = 3'h4,
      RDC_INTERNAL_OSC           = 3'h5,
      RDC_RESISTOR_CAPACITOR_OSC_IO = 3'h6,
      RDC_RESISTOR_CAPACITOR_OSC = 3'h7
   } rdc_clk_src_t;

   typedef struct packed {
      logic power_on;
      logic supply_droop;
      logic watchdog_run;
      logic watchdog_sleep;
      logic ext_run;
      logic ext_sleep;
   } rdc_cause_t;

   typedef struct packed {
      logic [1:0]   supply_droop_select;
      logic         internal_osc_speed;
      logic         code_lock;
      logic         external_reset_select;
      logic         power_up_delay_off;
      logic         watchdog_on;
      rdc_clk_src_t clk_src;
   } rdc_setup_t;

endpackage

// file: core/rdc_pin_filter.sv
// Purpose: Glitch filter on the external reset pin
// Assumes: Pin already synchronous to clk
// Notes:   Output changes only after a stable run of samples
`timescale 1ns/1ns
`include "rdc_defs.svh"
module rdc_pin_filter
   import rdc_pkg::*;
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic sys_rst,
   // Pin level and filtered result
   input  wire logic pin_n,
   output logic      filt_n
);
   logic [2:0] run_r;

   // ==========================================
   // Stable-run counter
   // short pulses ignored
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         run_r  <= 3'h0;
         filt_n <= 1'b1;
      end
      else if (pin_n == filt_n)
         run_r <= 3'h0;
      else if (run_r == 3'(`RDC_FILTER_CYCLES - 1))
      begin
         run_r  <= 3'h0;
         filt_n <= pin_n;
      end
      else
         run_r <= run_r + 3'h1;
   end

   // low pulse shorter than filter ignored
   chk_filter_short: assert property (@(posedge clk) disable iff (sys_rst)
      $fell(filt_n) |-> $past(pin_n, 1) == 1'b0 && $past(pin_n, 4) == 1'b0)
      else $error("Reset pin filter passed a short pulse");
endmodule // rdc_pin_filter

// file: core/rdc_delay_timer.sv
// Purpose: Down counter for one reset hold interval
// Assumes: tick is a one-cycle enable
// Notes:   done is held until start is pulsed again
`timescale 1ns/1ns
`include "rdc_defs.svh"
module rdc_delay_timer
   import rdc_pkg::*;
#(
   parameter int W = 24
)
(
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         sys_rst,
   // Control
   input  wire logic         start,
   input  wire logic         tick,
   input  wire logic [W-1:0] length,
   // Status
   output logic              busy,
   output logic              done
);
   logic [W-1:0] cnt_r;

   always_ff @(posedge clk)
   begin
      if (sys_rst || start)
      begin
         cnt_r <= length;
         busy  <= start;
         done  <= 1'b0;
      end
      else if (busy && tick)
      begin
         if (cnt_r <= W'(1))
         begin
            busy <= 1'b0;
            done <= 1'b1;
         end
         cnt_r <= cnt_r - W'(1);
      end
   end
endmodule // rdc_delay_timer

// file: core/rdc_reset_ctrl.sv
// Operation
// - Setup bits read 0 programmed, 1 unprogrammed; word at 2007h.
// - Special range 2000h-3FFFh reachable only in programming mode.
// - Droop select 11 always, 10 off in Sleep, 0x disabled.
// - Bit 7 picks internal oscillator 8 MHz or 4 MHz.
// - Bit 6 low locks code; unlocking erases all program memory.
// - Bit 5 low makes pin plain input, reset held inactive.
// - Power-up delay runs when bit 4 is 0.
// - Power-up delay holds reset 64 ms on power-up, RC clocked.
// - Bit 3 high enables the watchdog.
// - Three-bit field selects one of eight clock source modes.
// - Droop reset never implicitly enables the power-up delay.
// - Pin reset in internal or RC mode stops the oscillator.
// - Six reset causes are told apart.
// - Some registers keep value across non-power-on resets.
// - Watchdog wake-up resumes without reset; flags show the cause. In crystal modes core_rst is held until the settle timer ends.
// - External reset path filters short pulses.
// - Watchdog reset never drives the external pin low.
// - Reset held until supply adequate and above droop threshold.
// - Settle timer holds reset until crystal stable.
// - Sleep ends on external reset, watchdog wake or interrupt.
// - Calibration word survives bulk erase.
// - Power-up delay after power-on, settle timer after delay.
//
// Purpose: Reset sequencer and one-time setup word
// Assumes: Supply detectors and pins synchronous to clk
// Notes:   sys_rst stands for the analog power-on detector
`timescale 1ns/1ns
`include "rdc_defs.svh"
module rdc_reset_ctrl
   import rdc_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // Supply detectors
   input  wire logic        supply_ok,
   input  wire logic        above_droop,
   // Pin, watchdog and sleep
   input  wire logic        external_reset_pin_n,
   input  wire logic        watchdog_timeout,
   input  wire logic        sleep_req,
   input  wire logic        irq_wake,
   input  wire logic        osc_tick,
   // Programming port
   input  wire logic        prog_mode,
   input  wire logic [13:0] prog_addr,
   input  wire logic        prog_wr,
   input  wire logic [15:0] prog_wdata,
   input  wire logic        prog_bulk_erase,
   output logic      [15:0] prog_rdata,
   // Calibration load
   input  wire logic        calib_load,
   input  wire logic [15:0] calib_value,
   // Results
   output logic             core_rst,
   output logic             osc_stop,
   output logic             osc_fast,
   output logic             watchdog_enable,
   output logic             code_locked,
   output logic             erase_program_mem,
   output logic             pin_as_input,
   output logic             pin_drive_oe_n,
   output logic             in_sleep,
   output logic             watchdog_expired_flag,
   output logic             sleep_entered_flag,
   output rdc_cause_t       last_cause,
   output rdc_clk_src_t     clk_src_mode
);

   typedef enum logic [2:0] {RDC_HOLD, RDC_DELAY, RDC_SETTLE, RDC_RUN, RDC_SLEEP} rdc_state_t;

   rdc_state_t state_r;
   logic [15:0] setup_r;
   logic [15:0] calib_r;
   logic [2:0]  rcdiv_r;
   logic        rc_tick;
   logic        pin_filt_n;
   logic        pud_start;
   logic        pud_done;
   logic        ost_start;
   logic        ost_busy;
   logic        ost_done;
   logic        ext_hit;
   logic        droop_hit;
   logic        rst_req;
   logic        rst_sync_r;
   rdc_setup_t  cfg;

   // ==========================================
   // Setup word decode
   // field split
   function automatic rdc_setup_t decode(input logic [15:0] w);
      rdc_setup_t d;
      d.supply_droop_select   = w[`RDC_DROOP_HI:`RDC_DROOP_LO];
      d.internal_osc_speed    = w[`RDC_OSC_SPEED_BIT];
      d.code_lock             = w[`RDC_CODE_LOCK_BIT];
      d.external_reset_select = w[`RDC_EXT_RST_BIT];
      d.power_up_delay_off    = w[`RDC_PUD_OFF_BIT];
      d.watchdog_on           = w[`RDC_WDOG_ON_BIT];
      d.clk_src               = rdc_clk_src_t'(w[`RDC_CLKSRC_HI:`RDC_CLKSRC_LO]);
      return d;
   endfunction
   function automatic logic is_crystal(input rdc_clk_src_t m);
      return m == RDC_LOW_POWER_CRYSTAL || m == RDC_STANDARD_CRYSTAL || m == RDC_FAST_CRYSTAL;
   endfunction
   function automatic logic in_range(input logic [13:0] a);
      return a >= `RDC_SPECIAL_LO && a <= `RDC_SPECIAL_HI;
   endfunction

   assign cfg = decode(setup_r);

   // ==========================================
   // Setup and calibration storage
   // setup writes only in programming mode; calibration loads on calib_load in any mode
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         setup_r <= `RDC_SETUP_RESET;
      else if (prog_mode && prog_bulk_erase)
         setup_r <= `RDC_SETUP_RESET;
      else if (prog_mode && prog_wr && prog_addr == `RDC_SETUP_ADDR)
         setup_r <= prog_wdata | `RDC_UNIMPL_MASK;
   end
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         calib_r <= `RDC_CALIB_RESET;
      else if (calib_load)
         calib_r <= calib_value;
   end
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         prog_rdata <= 16'h0000;
      else if (prog_mode && prog_addr == `RDC_SETUP_ADDR)
         prog_rdata <= setup_r;
      else if (prog_mode && prog_addr == `RDC_CALIB_ADDR)
         prog_rdata <= calib_r;
      else if (prog_mode && in_range(prog_addr))
         prog_rdata <= 16'hFFFF;
      else
         prog_rdata <= 16'h0000;
   end
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         erase_program_mem <= 1'b0;
      else
         erase_program_mem <= prog_mode && prog_wr && prog_addr == `RDC_SETUP_ADDR
                              && !setup_r[`RDC_CODE_LOCK_BIT] && prog_wdata[`RDC_CODE_LOCK_BIT];
   end

   // ==========================================
   // RC tick divider for power-up delay
   // delay clocked from RC rate
   always_ff @(posedge clk)
   begin
      if (sys_rst || rcdiv_r == 3'(`RDC_RCDIV_CYCLES - 1))
         rcdiv_r <= 3'h0;
      else
         rcdiv_r <= rcdiv_r + 3'h1;
   end
   assign rc_tick = rcdiv_r == 3'(`RDC_RCDIV_CYCLES - 1);
   rdc_pin_filter u_filter (
      .clk     (clk),
      .sys_rst (sys_rst),
      .pin_n   (external_reset_pin_n),
      .filt_n  (pin_filt_n)
   );
   // pin ignored when used as input
   assign ext_hit = cfg.external_reset_select && !pin_filt_n;
   // droop mode 11 always, 10 except sleep
   assign droop_hit = cfg.supply_droop_select[1] && !above_droop
                      && (cfg.supply_droop_select[0] || state_r != RDC_SLEEP);
   assign rst_req = !supply_ok || droop_hit || ext_hit;
   rdc_delay_timer #(.W(24)) u_pud (
      .clk     (clk),
      .sys_rst (sys_rst),
      .start   (pud_start),
      .tick    (rc_tick),
      .length  (24'(`RDC_PUD_CYCLES / `RDC_RCDIV_CYCLES)),
      .busy    (),
      .done    (pud_done)
   );
   rdc_delay_timer #(.W(24)) u_ost (
      .clk     (clk),
      .sys_rst (sys_rst),
      .start   (ost_start),
      .tick    (osc_tick),
      .length  (24'(`RDC_SETTLE_TICKS)),
      .busy    (ost_busy),
      .done    (ost_done)
   );

   // ==========================================
   // Sequencer
   // delay then settle, delay only by own bit
   assign pud_start = state_r == RDC_HOLD && !rst_req && !cfg.power_up_delay_off;
   assign ost_start = (state_r == RDC_HOLD && !rst_req && cfg.power_up_delay_off
                       || state_r == RDC_DELAY && pud_done
                       || state_r == RDC_SLEEP && (irq_wake || watchdog_timeout && cfg.watchdog_on))
                      && is_crystal(cfg.clk_src);
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         state_r <= RDC_HOLD;
      else if (rst_req || (state_r == RDC_RUN && watchdog_timeout && cfg.watchdog_on))
         state_r <= RDC_HOLD;
      else
         unique case (state_r)
            RDC_HOLD:   state_r <= !cfg.power_up_delay_off ? RDC_DELAY
                                   : (is_crystal(cfg.clk_src) ? RDC_SETTLE : RDC_RUN);
            RDC_DELAY:  if (pud_done) state_r <= is_crystal(cfg.clk_src) ? RDC_SETTLE : RDC_RUN;
            RDC_SETTLE: if (ost_done) state_r <= RDC_RUN;
            RDC_RUN:    if (sleep_req) state_r <= RDC_SLEEP;
            RDC_SLEEP:  if (irq_wake || (watchdog_timeout && cfg.watchdog_on))
                           state_r <= is_crystal(cfg.clk_src) ? RDC_SETTLE : RDC_RUN;
         endcase
   end
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         rst_sync_r <= 1'b1;
      else
         rst_sync_r <= rst_req || !(state_r == RDC_RUN || state_r == RDC_SLEEP)
                       || (state_r == RDC_RUN && watchdog_timeout && cfg.watchdog_on);
   end
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         core_rst <= 1'b1;
      else
         core_rst <= rst_sync_r;
   end

   // ==========================================
   // Cause flags
   // flags kept over pin reset in run; power-on and droop reset set both
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         last_cause            <= '0;
         watchdog_expired_flag <= 1'b1;
         sleep_entered_flag    <= 1'b1;
      end
      else if (!supply_ok)
      begin
         last_cause            <= '{power_on: 1'b1, default: 1'b0};
         watchdog_expired_flag <= 1'b1;
         sleep_entered_flag    <= 1'b1;
      end
      else if (droop_hit)
      begin
         last_cause            <= '{supply_droop: 1'b1, default: 1'b0};
         watchdog_expired_flag <= 1'b1;
         sleep_entered_flag    <= 1'b1;
      end
      else if (ext_hit && state_r == RDC_SLEEP)
      begin
         last_cause            <= '{ext_sleep: 1'b1, default: 1'b0};
         watchdog_expired_flag <= 1'b1;
      end
      else if (ext_hit && state_r == RDC_RUN)
         last_cause <= '{ext_run: 1'b1, default: 1'b0};
      else if (watchdog_timeout && cfg.watchdog_on && state_r == RDC_RUN)
      begin
         last_cause            <= '{watchdog_run: 1'b1, default: 1'b0};
         watchdog_expired_flag <= 1'b0;
      end
      else if (watchdog_timeout && cfg.watchdog_on && state_r == RDC_SLEEP)
      begin
         last_cause            <= '{watchdog_sleep: 1'b1, default: 1'b0};
         watchdog_expired_flag <= 1'b0;
         sleep_entered_flag    <= 1'b0;
      end
      else if (state_r == RDC_RUN && sleep_req)
      begin
         watchdog_expired_flag <= 1'b1;
         sleep_entered_flag    <= 1'b0;
      end
   end

   // ==========================================
   // Registered outputs
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         osc_stop        <= 1'b0;
         osc_fast        <= 1'b1;
         watchdog_enable <= 1'b1;
         code_locked     <= 1'b0;
         pin_as_input    <= 1'b0;
         pin_drive_oe_n  <= 1'b1;
         in_sleep        <= 1'b0;
         clk_src_mode    <= RDC_RESISTOR_CAPACITOR_OSC;
      end
      else
      begin
         // pin reset stops internal or RC oscillator
         osc_stop        <= ext_hit && !is_crystal(cfg.clk_src) && cfg.clk_src != RDC_EXTERNAL_CLOCK_INPUT;
         osc_fast        <= cfg.internal_osc_speed;
         watchdog_enable <= cfg.watchdog_on;
         code_locked     <= !cfg.code_lock;
         pin_as_input    <= !cfg.external_reset_select;
         pin_drive_oe_n  <= 1'b1;
         in_sleep        <= state_r == RDC_SLEEP;
         clk_src_mode    <= cfg.clk_src;
      end
   end

   // ==========================================
   // Checks
   // watchdog reset keeps pin released
   chk_pin_never_driven: assert property (@(posedge clk) disable iff (sys_rst)
      watchdog_timeout |=> pin_drive_oe_n)
      else $error("Reset pin driven");
   chk_supply_holds: assert property (@(posedge clk) disable iff (sys_rst)
      !supply_ok |-> ##2 core_rst)
      else $error("Reset released with low supply");
   chk_pin_ignored: assert property (@(posedge clk) disable iff (sys_rst)
      !cfg.external_reset_select |=> !ext_hit || $changed(setup_r))
      else $error("Pin caused reset in input mode");
   sequence s_delay_end;
      state_r == RDC_DELAY && pud_done;
   endsequence
   chk_delay_order: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(ost_busy) && !cfg.power_up_delay_off && $past(state_r) != RDC_SLEEP
      |-> $past(pud_done))
      else $error("Settle timer started early");
   // droop off when upper bit clear
   chk_droop_off: assert property (@(posedge clk) disable iff (sys_rst)
      !cfg.supply_droop_select[1] |-> !droop_hit)
      else $error("Droop reset while disabled");
   chk_osc_stop: assert property (@(posedge clk) disable iff (sys_rst)
      ext_hit && cfg.clk_src[2] && $stable(setup_r) |=> osc_stop)
      else $error("Oscillator not stopped");
   chk_wake_no_reset: assert property (@(posedge clk) disable iff (sys_rst)
      state_r == RDC_SLEEP && watchdog_timeout && cfg.watchdog_on && !rst_req && !irq_wake
      |=> !sleep_entered_flag && !watchdog_expired_flag)
      else $error("Wake flags wrong");
   chk_range_hidden: assert property (@(posedge clk) disable iff (sys_rst)
      !prog_mode |=> prog_rdata == 16'h0000)
      else $error("Setup space readable");
endmodule // rdc_reset_ctrl

// file: dv/rdc_tb.sv
// Purpose: Self-checking bench for the reset sequencer
// Assumes: Power-up delay kept off, so no 64 ms waits
// Notes:   Inputs change 1 ns after the rising edge
`timescale 1ns/1ns
module tb;
   import rdc_pkg::*;
   // ==========
   // Signals
   logic         clk, sys_rst, supply_ok, above_droop, pin_n, wd_to;
   logic         sleep_req, irq_wake, osc_tick, prog_mode, prog_wr;
   logic         prog_bulk_erase, calib_load;
   logic [13:0]  prog_addr;
   logic [15:0]  prog_wdata, calib_value, prog_rdata;
   logic         core_rst, osc_stop, osc_fast, watchdog_enable, code_locked;
   logic         erase_program_mem, pin_as_input, pin_drive_oe_n, in_sleep;
   logic         watchdog_expired_flag, sleep_entered_flag;
   rdc_cause_t   last_cause;
   rdc_clk_src_t clk_src_mode;
   int           mismatches, comparisons, erase_cnt, e0;

   rdc_reset_ctrl rdc_reset_ctrl_inst (
      .clk(clk), .sys_rst(sys_rst), .supply_ok(supply_ok), .above_droop(above_droop),
      .external_reset_pin_n(pin_n), .watchdog_timeout(wd_to), .sleep_req(sleep_req),
      .irq_wake(irq_wake), .osc_tick(osc_tick), .prog_mode(prog_mode), .prog_addr(prog_addr),
      .prog_wr(prog_wr), .prog_wdata(prog_wdata), .prog_bulk_erase(prog_bulk_erase),
      .prog_rdata(prog_rdata), .calib_load(calib_load), .calib_value(calib_value),
      .core_rst(core_rst), .osc_stop(osc_stop), .osc_fast(osc_fast),
      .watchdog_enable(watchdog_enable), .code_locked(code_locked),
      .erase_program_mem(erase_program_mem), .pin_as_input(pin_as_input),
      .pin_drive_oe_n(pin_drive_oe_n), .in_sleep(in_sleep),
      .watchdog_expired_flag(watchdog_expired_flag), .sleep_entered_flag(sleep_entered_flag),
      .last_cause(last_cause), .clk_src_mode(clk_src_mode)
   );

   // ==========
   // Clock, oscillator ticks, erase pulse counter
   initial
   begin
      clk = 0;
      forever #25 clk = ~clk;
   end

   always @(posedge clk)
      osc_tick <= #1 ~osc_tick;

   always @(posedge clk)
      if (erase_program_mem === 1'b1)
         erase_cnt++;

   // ==========
   // Helpers
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic chk1(input string nm, input logic e, input logic g);
      comparisons++;
      if (g !== e)
      begin
         mismatches++;
         $display("ERROR %s expected %b seen %b", nm, e, g);
      end
   endtask

   task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e)
      begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wr(input logic m, input logic [15:0] d);
      prog_mode = m;
      prog_addr = 14'h2007;
      prog_wdata = d;
      prog_wr = 1;
      tick(1);
      prog_wr = 0;
      prog_mode = 0;
      tick(1);
   endtask

   task automatic rd(input logic m, input logic [13:0] a, input logic [15:0] e, input string nm);
      prog_mode = m;
      prog_addr = a;
      tick(1);
      chk16(nm, e, prog_rdata);
      prog_mode = 0;
   endtask

   // Selector 0 watches core_rst, 1 watches in_sleep
   task automatic wait_for(input int sel, input logic e, input int lim, input string nm);
      int n;
      n = 0;
      while (((sel == 0) ? core_rst : in_sleep) !== e && n < lim)
      begin
         tick(1);
         n++;
      end
      chk1(nm, e, (sel == 0) ? core_rst : in_sleep);
   endtask

   task automatic hold_rst(input logic e, input int n, input string nm);
      logic ok;
      ok = 1;
      repeat (n)
      begin
         tick(1);
         if (core_rst !== e)
            ok = 0;
      end
      chk1(nm, 1'b1, ok);
   endtask

   task automatic pulse_wd;
      wd_to = 1;
      tick(1);
      wd_to = 0;
   endtask

   task automatic pulse_sleep;
      sleep_req = 1;
      tick(1);
      sleep_req = 0;
   endtask

   task automatic done_test(input string nm);
      $display("test %s done, mismatches so far %0d", nm, mismatches);
   endtask

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial
   begin
      #1_000_000;
      mismatches++;
      final_report;
   end

   // ==========
   // Tests
   initial
   begin
      {supply_ok, wd_to, sleep_req, irq_wake, osc_tick, prog_mode, prog_wr} = '0;
      {prog_bulk_erase, calib_load, prog_addr, prog_wdata, calib_value} = '0;
      {mismatches, comparisons, erase_cnt} = '0;
      above_droop = 1;
      pin_n = 1;
      sys_rst = 1;
      tick(4);
      sys_rst = 0;
      hold_rst(1'b1, 20, "rst_low_supply");
      supply_ok = 1;
      wait_for(0, 1'b0, 200, "rst_release");
      chk1("cause_power_on", 1'b1, last_cause.power_on);
      rd(1, 14'h2007, 16'hFFFF, "setup_reset");
      done_test("power_on");

      rd(0, 14'h2007, 16'h0000, "rd_user_mode");
      rd(1, 14'h1FFF, 16'h0000, "rd_user_space");
      rd(1, 14'h3FFF, 16'hFFFF, "rd_special_top");
      wr(0, 16'h0000);
      rd(1, 14'h2007, 16'hFFFF, "wr_user_ignored");
      wr(1, 16'h0216);
      rd(1, 14'h2007, 16'hFE16, "setup_readback");
      chk1("osc_fast", 1'b0, osc_fast);
      chk1("code_locked", 1'b1, code_locked);
      chk1("pin_as_input", 1'b1, pin_as_input);
      chk1("wdog_en", 1'b0, watchdog_enable);
      e0 = erase_cnt;
      for (int i = 0; i < 8; i++)
      begin
         wr(1, 16'hFCF8 | 16'(i));
         chk16("clk_src", 16'(i), {13'h0000, clk_src_mode});
      end
      tick(2);
      chk16("erase_pulses", 16'h0001, 16'(erase_cnt - e0));
      chk1("osc_fast_hi", 1'b1, osc_fast);
      chk1("wdog_en_hi", 1'b1, watchdog_enable);
      done_test("setup_word");

      calib_value = 16'h1234;
      calib_load = 1;
      tick(1);
      calib_load = 0;
      wr(1, 16'hFCF7);
      prog_mode = 1;
      prog_bulk_erase = 1;
      tick(1);
      prog_bulk_erase = 0;
      tick(1);
      rd(1, 14'h2007, 16'hFFFF, "bulk_setup");
      rd(1, 14'h2008, 16'h1234, "bulk_calib");
      done_test("bulk_erase");

      pin_n = 0;
      tick(2);
      pin_n = 1;
      hold_rst(1'b0, 8, "pin_glitch");
      pin_n = 0;
      wait_for(0, 1'b1, 20, "pin_reset");
      chk1("osc_stop", 1'b1, osc_stop);
      chk1("cause_ext_run", 1'b1, last_cause.ext_run);
      pin_n = 1;
      wait_for(0, 1'b0, 50, "pin_release");
      wr(1, 16'hFFDF);
      pin_n = 0;
      hold_rst(1'b0, 12, "pin_as_io");
      pin_n = 1;
      // Let the filter see the pin high again before reset use returns
      tick(6);
      done_test("ext_pin");

      wr(1, 16'hFFF7);
      pulse_wd;
      hold_rst(1'b0, 6, "wdog_off");
      wr(1, 16'hFFFF);
      pulse_wd;
      wait_for(0, 1'b1, 10, "wdog_reset");
      chk1("pin_oe_n", 1'b1, pin_drive_oe_n);
      chk1("cause_wdog_run", 1'b1, last_cause.watchdog_run);
      chk1("expired_flag", 1'b0, watchdog_expired_flag);
      wait_for(0, 1'b0, 50, "wdog_release");
      done_test("watchdog");

      above_droop = 0;
      wait_for(0, 1'b1, 20, "droop_reset");
      chk1("cause_droop", 1'b1, last_cause.supply_droop);
      hold_rst(1'b1, 10, "droop_hold");
      above_droop = 1;
      wait_for(0, 1'b0, 50, "droop_no_delay");
      wr(1, 16'hFCFF);
      above_droop = 0;
      hold_rst(1'b0, 10, "droop_off");
      above_droop = 1;
      done_test("droop");

      wr(1, 16'hFEFF);
      pulse_sleep;
      wait_for(1, 1'b1, 10, "sleep_enter");
      above_droop = 0;
      hold_rst(1'b0, 10, "droop_sleep_off");
      above_droop = 1;
      irq_wake = 1;
      wait_for(1, 1'b0, 10, "irq_wake");
      irq_wake = 0;
      pulse_sleep;
      wait_for(1, 1'b1, 10, "sleep_again");
      pulse_wd;
      wait_for(1, 1'b0, 10, "wdog_wake");
      hold_rst(1'b0, 6, "wake_no_reset");
      chk1("sleep_flag", 1'b0, sleep_entered_flag);
      chk1("expired_wake", 1'b0, watchdog_expired_flag);
      chk1("cause_wdog_sleep", 1'b1, last_cause.watchdog_sleep);
      pulse_sleep;
      wait_for(1, 1'b1, 10, "sleep_third");
      pin_n = 0;
      wait_for(0, 1'b1, 20, "pin_sleep_reset");
      chk1("cause_ext_sleep", 1'b1, last_cause.ext_sleep);
      pin_n = 1;
      wait_for(0, 1'b0, 50, "pin_sleep_release");
      done_test("sleep");

      wr(1, 16'hFFF9);
      above_droop = 0;
      wait_for(0, 1'b1, 20, "droop_crystal");
      above_droop = 1;
      hold_rst(1'b1, 1000, "settle_hold");
      wait_for(0, 1'b0, 4000, "settle_release");
      done_test("settle_timer");

      final_report;
   end
endmodule // tb
